/* design/wbm_port.sv */
// Bus master port: single classic cycles for the core's loads and stores
// Functional notes
// [RULE1] Master with 32-bit address, write and read data, write enable, acknowledge.
// [RULE2] Strobe stays high for the whole read or write cycle.
// [RULE3] Cycle high while a valid bus cycle is in progress, low otherwise.
// [RULE4] Lock high for uninterruptible cycles; arbiter must not regrant meanwhile.
// [RULE5] Cycle-type and burst-type driven constant; slaves must not rely on them.
// [RULE6] Word selects 1111; halfword 0011 if address bit 1 set, else 1100.
// [RULE7] Byte select one-hot from low address bits, 00 gives 1000.
// [RULE8] Big-endian: lowest address byte carries the most significant bits.
// [RULE9] All bus activity on the input clock; core clock output equals it.
// [RULE10] Address, data, select, write enable held stable until acknowledge.
// [RULE11] Read data sampled at acknowledge edge, only enabled lanes for loads.
`timescale 1ns/1ps
`default_nettype none
module wbm_port (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    output logic core_clk,
    // Core request
    input wire logic req_valid,
    input wire wbm_pkg::wbm_req_type req,
    output logic req_ready,
    output wbm_pkg::wbm_rsp_type rsp,
    // Bus
    input wire logic [wbm_pkg::DATA_W-1:0] bus_read_data_in,
    input wire logic bus_acknowledge_in,
    input wire logic bus_error_in,
    output logic [wbm_pkg::DATA_W-1:0] bus_write_data_out,
    output logic [wbm_pkg::SEL_W-1:0] bus_byte_select_out,
    output logic bus_write_enable_out,
    output logic bus_strobe_out,
    output logic bus_cycle_out,
    output logic bus_lock_out,
    output logic [wbm_pkg::ADDR_W-1:0] bus_address_out,
    output logic [wbm_pkg::CTI_W-1:0] bus_cycle_type_out,
    output logic [wbm_pkg::BTE_W-1:0] bus_burst_type_out
);
    import wbm_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        wbm_state_type st;
        wbm_bus_type bus;
        wbm_size_type size;
        wbm_rsp_type rsp;
    } wbm_regs_type;

    wbm_regs_type s_r;
    wbm_regs_type s_nxt;
    logic [SEL_W-1:0] sel;
    logic [DATA_W-1:0] lane_wdata;
    logic [DATA_W-1:0] lane_rdata;

    // ****************************************
    // Lane steering
    // ****************************************
    // Write side decodes the incoming request; read side the held address
    logic [1:0] lane_addr;
    wbm_size_type lane_size;
    assign lane_addr = (s_r.st == WBM_BUSY) ? s_r.bus.adr[1:0] : req.addr[1:0];
    assign lane_size = (s_r.st == WBM_BUSY) ? s_r.size : req.size;

    wbm_lane u_lane (
        .addr_lo(lane_addr),
        .size(lane_size),
        .wdata(req.wdata),
        .bus_rdata(bus_read_data_in),
        .sel(sel),
        .lane_wdata(lane_wdata),
        .lane_rdata(lane_rdata)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_nxt = s_r;
        s_nxt.rsp.done = 1'b0;
        s_nxt.rsp.err = 1'b0;
        s_nxt.bus.cti = CTI_CLASSIC; // see [RULE5]
        s_nxt.bus.bte = BTE_LINEAR; // see [RULE5]
        case (s_r.st)
            WBM_IDLE: begin
                if (req_valid) begin
                    s_nxt.st = WBM_BUSY;
                    s_nxt.bus.adr = req.addr; // see [RULE1]
                    s_nxt.bus.dat = lane_wdata;
                    s_nxt.bus.sel = sel; // see [RULE6]
                    s_nxt.bus.we = req.write;
                    s_nxt.bus.stb = 1'b1; // see [RULE2]
                    s_nxt.bus.cyc = 1'b1; // see [RULE3]
                    s_nxt.bus.lock = req.lock; // see [RULE4]
                    s_nxt.size = req.size;
                end else begin
                    s_nxt.bus.lock = 1'b0;
                end
            end
            WBM_BUSY: begin
                // Outputs held untouched until the slave answers
                if (bus_acknowledge_in || bus_error_in) begin // see [RULE10]
                    s_nxt.st = WBM_IDLE;
                    s_nxt.bus.stb = 1'b0; // see [RULE2]
                    s_nxt.bus.cyc = 1'b0; // see [RULE3]
                    s_nxt.bus.we = 1'b0;
                    // Lock drops on entering idle, even if the core chains another
                    s_nxt.bus.lock = 1'b0; // see [RULE4]
                    s_nxt.rsp.done = 1'b1;
                    s_nxt.rsp.err = bus_error_in && !bus_acknowledge_in;
                    if (!s_r.bus.we && bus_acknowledge_in) begin
                        s_nxt.rsp.rdata = lane_rdata; // see [RULE11]
                    end
                end
            end
            default: s_nxt.st = WBM_IDLE;
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    // Clock enable low freezes every flop, bus cycle included
    always_ff @(posedge clk or negedge rst_n) begin // see [RULE9]
        if (!rst_n) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign core_clk = clk; // see [RULE9]
    assign req_ready = (s_r.st == WBM_IDLE);
    assign rsp = s_r.rsp;
    assign bus_address_out = s_r.bus.adr;
    assign bus_write_data_out = s_r.bus.dat;
    assign bus_byte_select_out = s_r.bus.sel;
    assign bus_write_enable_out = s_r.bus.we;
    assign bus_strobe_out = s_r.bus.stb;
    assign bus_cycle_out = s_r.bus.cyc;
    assign bus_lock_out = s_r.bus.lock;
    assign bus_cycle_type_out = s_r.bus.cti;
    assign bus_burst_type_out = s_r.bus.bte;
endmodule
`default_nettype wire

/* shared/wbm_pkg.sv */
// Package for the bus master port: constants, sizes and carrier structs
package wbm_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int SEL_W = 4;
    localparam int CTI_W = 3;
    localparam int BTE_W = 2;

    // Access sizes requested by the core
    typedef enum logic [1:0] {
        WBM_SZ_BYTE = 2'b00,
        WBM_SZ_HALF = 2'b01,
        WBM_SZ_WORD = 2'b10
    } wbm_size_type;

    // Byte select patterns, big-endian lane order
    localparam logic [3:0] SEL_WORD = 4'hF;
    localparam logic [3:0] SEL_HALF_HI = 4'hC;
    localparam logic [3:0] SEL_HALF_LO = 4'h3;
    localparam logic [3:0] SEL_BYTE0 = 4'h8;
    localparam logic [3:0] SEL_BYTE1 = 4'h4;
    localparam logic [3:0] SEL_BYTE2 = 4'h2;
    localparam logic [3:0] SEL_BYTE3 = 4'h1;
    localparam logic [2:0] CTI_CLASSIC = 3'h0;
    localparam logic [1:0] BTE_LINEAR = 2'h0;
    localparam int HALF_BIT = 1;
    localparam int BYTE_W = 8;
    localparam int HALF_W = 16;

    // Core-side request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        wbm_size_type size;
        logic write;
        logic lock;
    } wbm_req_type;

    // Bus-side outputs
    typedef struct packed {
        logic [ADDR_W-1:0] adr;
        logic [DATA_W-1:0] dat;
        logic [SEL_W-1:0] sel;
        logic we;
        logic stb;
        logic cyc;
        logic lock;
        logic [CTI_W-1:0] cti;
        logic [BTE_W-1:0] bte;
    } wbm_bus_type;

    // Core-side answer
    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic done;
        logic err;
    } wbm_rsp_type;

    typedef enum logic [0:0] {
        WBM_IDLE = 1'b0,
        WBM_BUSY = 1'b1
    } wbm_state_type;
endpackage

/* design/wbm_lane.sv */
// Byte lane steering: select decode, write placement, read extraction
`timescale 1ns/1ps
`default_nettype none
module wbm_lane (
    // Access
    input wire logic [1:0] addr_lo,
    input wire wbm_pkg::wbm_size_type size,
    input wire logic [wbm_pkg::DATA_W-1:0] wdata,
    input wire logic [wbm_pkg::DATA_W-1:0] bus_rdata,
    // Results
    output logic [wbm_pkg::SEL_W-1:0] sel,
    output logic [wbm_pkg::DATA_W-1:0] lane_wdata,
    output logic [wbm_pkg::DATA_W-1:0] lane_rdata
);
    import wbm_pkg::*;

    function automatic logic [SEL_W-1:0] sel_of(input logic [1:0] a, input wbm_size_type s);
        case (s)
            WBM_SZ_WORD: sel_of = SEL_WORD; // see [RULE6]
            WBM_SZ_HALF: sel_of = a[HALF_BIT] ? SEL_HALF_LO : SEL_HALF_HI; // see [RULE6]
            default: begin
                case (a)
                    2'h0: sel_of = SEL_BYTE0; // see [RULE7]
                    2'h1: sel_of = SEL_BYTE1;
                    2'h2: sel_of = SEL_BYTE2;
                    default: sel_of = SEL_BYTE3;
                endcase
            end
        endcase
    endfunction

    always_comb begin
        sel = sel_of(addr_lo, size);
        lane_wdata = '0;
        lane_rdata = '0;
        case (size)
            // Lowest address lands on the most significant lane
            WBM_SZ_WORD: begin
                lane_wdata = wdata;
                lane_rdata = bus_rdata;
            end
            WBM_SZ_HALF: begin
                lane_wdata = {2{wdata[HALF_W-1:0]}}; // see [RULE8]
                lane_rdata[HALF_W-1:0] = addr_lo[HALF_BIT] ? bus_rdata[HALF_W-1:0]
                                                           : bus_rdata[DATA_W-1:HALF_W]; // see [RULE11]
            end
            default: begin
                lane_wdata = {4{wdata[BYTE_W-1:0]}}; // see [RULE8]
                case (addr_lo)
                    2'h0: lane_rdata[BYTE_W-1:0] = bus_rdata[31:24]; // see [RULE11]
                    2'h1: lane_rdata[BYTE_W-1:0] = bus_rdata[23:16];
                    2'h2: lane_rdata[BYTE_W-1:0] = bus_rdata[15:8];
                    default: lane_rdata[BYTE_W-1:0] = bus_rdata[7:0];
                endcase
            end
        endcase
    end
endmodule
`default_nettype wire

/* verif/wbm_slave_model.sv */
// Slave memory model with wait states and an error region
`timescale 1ns/1ps
`default_nettype none
module wbm_slave_model (
    // Bus in
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stb,
    input wire logic we,
    input wire logic stall,
    input wire logic [31:0] adr,
    input wire logic [31:0] wd,
    input wire logic [3:0] sel,
    // Answer
    output logic [31:0] rd,
    output logic ack,
    output logic err
);
    // Cycle and burst type not even wired in
    logic [31:0] mem [0:15];
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            err <= 1'b0;
            rd <= 32'h0;
        end else begin
            ack <= 1'b0;
            err <= 1'b0;
            // Stale data toggles so it never matches by luck
            rd <= ~rd;
            if (stb && !ack && !err && !stall) begin
                if (adr[31]) begin
                    err <= 1'b1;
                end else begin
                    ack <= 1'b1;
                    if (!we) rd <= mem[adr[5:2]];
                    for (int i = 0; i < 4; i++) begin
                        if (we && sel[i]) mem[adr[5:2]][8*i+:8] <= wd[8*i+:8];
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

/* verif/wbm_port_props.sv */
// Checker for the bus master port
`timescale 1ns/1ps
`default_nettype none
module wbm_port_props (
    // Watched ports
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic core_clk,
    input wire wbm_pkg::wbm_req_type req,
    input wire wbm_pkg::wbm_rsp_type rsp,
    input wire logic bus_acknowledge_in,
    input wire logic bus_error_in,
    input wire logic [31:0] bus_write_data_out,
    input wire logic [3:0] bus_byte_select_out,
    input wire logic bus_write_enable_out,
    input wire logic bus_strobe_out,
    input wire logic bus_cycle_out,
    input wire logic bus_lock_out,
    input wire logic [31:0] bus_address_out,
    input wire logic [2:0] bus_cycle_type_out,
    input wire logic [1:0] bus_burst_type_out
);
    import wbm_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_stb; bus_strobe_out == bus_cycle_out; endproperty
    a_stb: assert property (p_stb) else $error("strobe");
    property p_hold; bus_cycle_out && !(ce && (bus_acknowledge_in || bus_error_in)) |=>
        bus_cycle_out && $stable({bus_address_out, bus_write_data_out,
        bus_byte_select_out, bus_write_enable_out}); endproperty
    a_hold: assert property (p_hold) else $error("hold");
    property p_end; bus_cycle_out && ce && bus_acknowledge_in |=> !bus_cycle_out && rsp.done;
    endproperty
    a_end: assert property (p_end) else $error("end");
    property p_lock; !bus_cycle_out |-> !bus_lock_out; endproperty
    a_lock: assert property (p_lock) else $error("lock");
    property p_start; $rose(bus_cycle_out) |-> bus_lock_out == $past(req.lock)
        && bus_address_out == $past(req.addr); endproperty
    a_start: assert property (p_start) else $error("start");
    property p_byte; $onehot(bus_byte_select_out) |->
        bus_byte_select_out == 4'h8 >> bus_address_out[1:0]; endproperty
    a_byte: assert property (p_byte) else $error("byte");
    property p_half; bus_cycle_out && $countones(bus_byte_select_out) == 2 |->
        bus_byte_select_out == (bus_address_out[1] ? 4'h3 : 4'hC); endproperty
    a_half: assert property (p_half) else $error("half");
    property p_type; bus_cycle_type_out == 3'h0 && bus_burst_type_out == 2'h0; endproperty
    a_type: assert property (p_type) else $error("type");
    property p_clk; @(negedge clk) core_clk; endproperty
    a_clk: assert property (p_clk) else $error("clock");
    c_rd: cover property (bus_cycle_out && !bus_write_enable_out && bus_acknowledge_in);
    c_wr: cover property (bus_cycle_out && bus_write_enable_out && bus_acknowledge_in);
    c_lk: cover property (bus_lock_out && bus_acknowledge_in);
endmodule
bind wbm_port wbm_port_props wbm_port_props_inst (.*);
`default_nettype wire

/* verif/wbm_port_bench.sv */
// Self-checking bench for the bus master port
`timescale 1ns/1ps
`default_nettype none
module wbm_port_bench;
    import wbm_pkg::*;
    logic clk = 0, rst_n = 0, ce = 0, req_valid = 0, stall = 0;
    wbm_req_type req = '0;
    wbm_rsp_type rsp;
    logic req_ready, ack, err, we, stb, cyc;
    logic [31:0] rd, wd, adr, last_rd = '0;
    logic [3:0] sel;
    logic [7:0] ref_mem [0:63];
    int fails = 0, samples_checked = 0, seed = 32'he01f;
    always #12.5 clk = ~clk;
    wbm_port wbm_port_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .core_clk(),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp(rsp),
        .bus_read_data_in(rd), .bus_acknowledge_in(ack), .bus_error_in(err),
        .bus_write_data_out(wd), .bus_byte_select_out(sel), .bus_write_enable_out(we),
        .bus_strobe_out(stb), .bus_cycle_out(cyc), .bus_lock_out(), .bus_address_out(adr),
        .bus_cycle_type_out(), .bus_burst_type_out());
    wbm_slave_model wbm_slave_model_inst (.clk(clk), .rst_n(rst_n), .stb(stb), .we(we),
        .stall(stall), .adr(adr), .wd(wd), .sel(sel), .rd(rd), .ack(ack), .err(err));
    // Random stalls on both sides
    always @(posedge clk) begin
        stall <= $random(seed) % 3 == 0;
        ce <= ($random(seed) & 7) != 0;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic access(input logic w, input logic [1:0] sz, input logic [31:0] a,
        input logic [31:0] d);
        int n;
        int len;
        int al;
        logic [31:0] e;
        len = 1 << sz;
        al = a[5:0] & ~(len - 1);
        req_valid <= 1'b1;
        req <= '{a, d, wbm_size_type'(sz), w, a[2]};
        do @(posedge clk); while (!(ce && req_ready));
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(rsp.done || rsp.err) && n < 200);
        if (n == 200) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        end
        check(32'(rsp.err), 32'(a[31]));
        if (rsp.err) begin
            check(rsp.rdata, last_rd);
        end else if (w) begin
            for (n = 0; n < len; n++) ref_mem[al+n] = d[8*(len-1-n)+:8];
        end else begin
            e = '0;
            for (n = 0; n < len; n++) e = {e[23:0], ref_mem[al+n]};
            check(rsp.rdata, e);
            last_rd = e;
        end
    endtask
    task automatic report_and_stop;
        if (fails == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        logic [31:0] r;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 16; i++) access(1'b1, 2'h2, 32'(i * 4), $random(seed));
        for (int i = 0; i < 400; i++) begin
            r = $random(seed);
            access(r[0], (r[2:1] == 2'h3) ? 2'h2 : r[2:1], {r[9:7] == 3'h0, 25'h0, r[15:10]},
                $random(seed));
        end
        report_and_stop();
    end
    initial begin
        #2000000;
        fails++;
        report_and_stop();
    end
endmodule
`default_nettype wire
